// file: aspsr_regs.svh
/*
  Constants of the converter's serial port: register selects, comms field
  positions, reset values and timing counts.
  Assumes a 20 MHz system clock; included by its bare name.
*/
`ifndef ASPSR_REGS_SVH
`define ASPSR_REGS_SVH

// ----------------------------------------------------------------------
// Register selects
// ----------------------------------------------------------------------
`define ASPSR_SEL_STATUS    3'h0
`define ASPSR_SEL_MODE      3'h1
`define ASPSR_SEL_CONFIG    3'h2
`define ASPSR_SEL_DATA      3'h3
`define ASPSR_SEL_ID        3'h4
`define ASPSR_SEL_GPOCON    3'h5

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ASPSR_COMMS_WEN_BIT  7
`define ASPSR_COMMS_RW_BIT   6
`define ASPSR_COMMS_SEL_HI   5
`define ASPSR_COMMS_SEL_LO   3
`define ASPSR_STATUS_RDY_BIT 7
`define ASPSR_CFG_REFERENCE_SELECT_BIT 20

// ----------------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------------
`define ASPSR_MODE_RST      24'h000000
`define ASPSR_CONFIG_RST    24'h000000
`define ASPSR_GPOCON_RST    8'h00
// Arbitrary identification value
`define ASPSR_ID_VALUE      8'h5a
`define ASPSR_BITS_SHORT    5'h08
`define ASPSR_BITS_LONG     5'h18
`define ASPSR_FIFO_DEPTH    32

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ASPSR_CLK_MHZ       20
`define ASPSR_RDY_GAP_NS    100
`define ASPSR_RDY_GAP_CYC   ((`ASPSR_RDY_GAP_NS * `ASPSR_CLK_MHZ + 999) / 1000)

`endif

// file: aspsr_pkg.sv
/*
  Types of the converter's serial port: port state and pin groups.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package aspsr_pkg;

  typedef enum logic [1:0] {
    ASPSR_ST_COMMS = 2'b00,
    ASPSR_ST_READ  = 2'b01,
    ASPSR_ST_WRITE = 2'b10
  } aspsr_state_e;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } aspsr_serial_s;

  typedef struct packed {
    logic [3:0] value;
    logic [3:0] oe_n;
  } aspsr_gpo_s;

endpackage

// file: aspsr_fifo.sv
/*
  Result FIFO with registered read data and valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset; flush empties it.
*/
`timescale 1ns/10ps
`default_nettype none

module aspsr_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             flush_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic      [WIDTH-1:0] rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic [WIDTH-1:0] out_r, out_nxt;
  logic             ov_r, ov_nxt;
  logic             push, pop;

  assign wr_ready_out = (cnt_r != (AW+1)'(DEPTH)) && !flush_in;
  assign rd_data_out  = out_r;
  assign rd_valid_out = ov_r;

  always_comb
  begin
    push    = wr_valid_in && wr_ready_out;
    pop     = (cnt_r != '0) && (!ov_r || rd_ready_in);
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    out_nxt = pop ? mem[rp_r] : out_r;
    ov_nxt  = pop ? 1'b1 : (rd_ready_in ? 1'b0 : ov_r);
    if (flush_in)
    begin
      wp_nxt  = '0;
      rp_nxt  = '0;
      cnt_nxt = '0;
      ov_nxt  = 1'b0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (push)
      mem[wp_r] <= wr_data_in;
    if (reset_in)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      out_r <= '0;
      ov_r  <= 1'b0;
    end
    else
    begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
      ov_r  <= ov_nxt;
    end
  end

endmodule // aspsr_fifo

`default_nettype wire

// file: aspsr_serial_port.sv
/*
  Digital side of a sigma-delta converter's host port: three-wire serial
  slave, combined data-out/ready pin, filter sync input and GPO pins.
  Assumes the host is serial master with SCLK well below clk_in / 4, and
  that the converter core delivers results over a valid/ready stream.
*/
// Summary of operation
// RULE1: While sync is low, hold filter, filter control, calibration and modulator reset.
// RULE2: Sync never disturbs serial state, transfers in flight or the register pointer.
// RULE3: Sync low returns a low ready indication to high.
// RULE4: Data-out pin shifts out a shift register loaded from any readable register.
// RULE5: Data-out pin falls when a new conversion result is available.
// RULE6: Unread result: ready goes high before the data register takes the next result.
// RULE7: Host may treat the ready falling edge as a data-valid interrupt.
// RULE8: Output bits change on SCLK falling edges; host samples on rising edges.
// RULE9: Input bits shift in, then go to the register the comms select field names.
// RULE10: Reference-select set turns the two shared pins into second reference inputs.
// RULE11: Dedicated pins act as host-controlled general-purpose outputs.
// RULE12: Sync release restarts filtering from a fresh state, in step across devices.
`include "aspsr_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module aspsr_serial_port
  import aspsr_pkg::*;
(
  input  wire logic           clk_in,
  input  wire logic           reset_in,
  input  wire aspsr_serial_s  serial_in,
  output logic                dout_rdy_out,
  output logic                dout_rdy_oe_n_out,
  input  wire logic           sync_n_in,
  input  wire logic [23:0]    result_in,
  input  wire logic           result_valid_in,
  output logic                result_ready_out,
  output logic                filter_reset_out,
  output logic                filter_restart_out,
  output logic [23:0]         mode_out,
  output logic [23:0]         config_out,
  output logic                ref2_active_out,
  output var aspsr_gpo_s      gpo_out
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic [4:0] reg_bits(input logic [2:0] sel);
    case (sel)
      `ASPSR_SEL_MODE, `ASPSR_SEL_CONFIG, `ASPSR_SEL_DATA: reg_bits = `ASPSR_BITS_LONG;
      default:                                             reg_bits = `ASPSR_BITS_SHORT;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  aspsr_serial_s ser_s1_r, ser_s2_r;
  logic          sclk_s3_r, sync_s1_r, sync_s2_r, sync_s3_r;
  logic          sclk_rise, sclk_fall, selected;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      ser_s1_r  <= '{cs_n: 1'b1, sclk: 1'b1, din: 1'b1};
      ser_s2_r  <= '{cs_n: 1'b1, sclk: 1'b1, din: 1'b1};
      sclk_s3_r <= 1'b1;
      sync_s1_r <= 1'b1;
      sync_s2_r <= 1'b1;
      sync_s3_r <= 1'b1;
    end
    else
    begin
      ser_s1_r  <= serial_in;
      ser_s2_r  <= ser_s1_r;
      sclk_s3_r <= ser_s2_r.sclk;
      sync_s1_r <= sync_n_in;
      sync_s2_r <= sync_s1_r;
      sync_s3_r <= sync_s2_r;
    end
  end

  assign selected  = !ser_s2_r.cs_n;
  assign sclk_rise = selected && ser_s2_r.sclk && !sclk_s3_r;
  assign sclk_fall = selected && !ser_s2_r.sclk && sclk_s3_r;

  // ----------------------------------------------------------------------
  // Result FIFO
  // ----------------------------------------------------------------------
  logic [23:0] fifo_data;
  logic        fifo_valid, fifo_take;

  // Results pile up here while the data register is being read or the core outpaces it; back-pressure reaches the core
  aspsr_fifo #(
    .WIDTH (24),
    .DEPTH (`ASPSR_FIFO_DEPTH)
  ) u_fifo (
    .clk_in       (clk_in),
    .reset_in     (reset_in),
    .flush_in     (!sync_s2_r),
    .wr_data_in   (result_in),
    .wr_valid_in  (result_valid_in),
    .wr_ready_out (result_ready_out),
    .rd_data_out  (fifo_data),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (fifo_take)
  );

  // ----------------------------------------------------------------------
  // Port state
  // ----------------------------------------------------------------------
  aspsr_state_e st_r, st_nxt;
  logic [4:0]   cnt_r, cnt_nxt;
  logic [23:0]  sh_r, sh_nxt;
  logic [2:0]   sel_r, sel_nxt;
  logic [23:0]  mode_r, mode_nxt, cfg_r, cfg_nxt, data_r, data_nxt;
  logic [7:0]   gpocon_r, gpocon_nxt, comms;
  logic         full_r, full_nxt, rdy_n_r, rdy_n_nxt, dout_r, dout_nxt;
  logic [3:0]   gap_r, gap_nxt;
  logic [23:0]  rd_word;
  logic         data_busy;

  always_comb
  begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    sh_nxt     = sh_r;
    sel_nxt    = sel_r;
    mode_nxt   = mode_r;
    cfg_nxt    = cfg_r;
    data_nxt   = data_r;
    gpocon_nxt = gpocon_r;
    full_nxt   = full_r;
    rdy_n_nxt  = rdy_n_r;
    gap_nxt    = gap_r;
    fifo_take  = 1'b0;
    comms      = '0;
    rd_word    = '0;

    // Serial engine runs regardless of sync
    if (sclk_rise) // RULE2
    begin
      case (st_r)
        ASPSR_ST_COMMS:
        begin
          sh_nxt  = {sh_r[22:0], ser_s2_r.din};
          cnt_nxt = cnt_r + 5'h01;
          comms   = sh_nxt[7:0];
          if (cnt_r == 5'h07)
          begin
            cnt_nxt = '0;
            // A set write-enable bit keeps the port waiting for a comms byte
            if (!comms[`ASPSR_COMMS_WEN_BIT])
            begin
              sel_nxt = comms[`ASPSR_COMMS_SEL_HI:`ASPSR_COMMS_SEL_LO];
              st_nxt  = comms[`ASPSR_COMMS_RW_BIT] ? ASPSR_ST_READ : ASPSR_ST_WRITE; // RULE9
            end
          end
        end
        ASPSR_ST_WRITE:
        begin
          sh_nxt  = {sh_r[22:0], ser_s2_r.din}; // RULE9
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == reg_bits(sel_r) - 5'h01)
          begin
            cnt_nxt = '0;
            st_nxt  = ASPSR_ST_COMMS;
            case (sel_r) // RULE9
              `ASPSR_SEL_MODE:   mode_nxt   = sh_nxt;
              `ASPSR_SEL_CONFIG: cfg_nxt    = sh_nxt;
              `ASPSR_SEL_GPOCON: gpocon_nxt = sh_nxt[7:0];
              default:           ;
            endcase
          end
        end
        ASPSR_ST_READ:
        begin
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == reg_bits(sel_r) - 5'h01)
          begin
            cnt_nxt = '0;
            st_nxt  = ASPSR_ST_COMMS;
            if (sel_r == `ASPSR_SEL_DATA)
            begin
              full_nxt  = 1'b0;
              rdy_n_nxt = 1'b1;
            end
          end
        end
        default:
        begin
          st_nxt  = ASPSR_ST_COMMS;
          cnt_nxt = '0;
        end
      endcase
    end

    // Readable registers, left aligned; the freshly decoded select picks one
    case (sel_nxt)
      `ASPSR_SEL_STATUS: rd_word = {rdy_n_r, 7'h00, 16'h0000};
      `ASPSR_SEL_MODE:   rd_word = mode_r;
      `ASPSR_SEL_CONFIG: rd_word = cfg_r;
      `ASPSR_SEL_DATA:   rd_word = data_r;
      `ASPSR_SEL_ID:     rd_word = {`ASPSR_ID_VALUE, 16'h0000};
      `ASPSR_SEL_GPOCON: rd_word = {gpocon_r, 16'h0000};
      default:           rd_word = '0;
    endcase

    // Load the shift register once the read command is decoded
    if (st_r != ASPSR_ST_READ && st_nxt == ASPSR_ST_READ)
      sh_nxt = rd_word; // RULE4

    // Data register never changes under a read of it
    data_busy = (st_r == ASPSR_ST_READ) && (sel_r == `ASPSR_SEL_DATA);

    if (!sync_s2_r)
    begin
      full_nxt  = 1'b0;
      rdy_n_nxt = 1'b1; // RULE3
      gap_nxt   = '0;
    end
    else if (fifo_valid && !data_busy)
    begin
      if (!full_r)
      begin
        fifo_take = 1'b1;
        data_nxt  = fifo_data;
        full_nxt  = 1'b1;
        rdy_n_nxt = 1'b0; // RULE5
      end
      else if (gap_r == 4'(`ASPSR_RDY_GAP_CYC))
      begin
        fifo_take = 1'b1;
        data_nxt  = fifo_data;
        rdy_n_nxt = 1'b0;
        gap_nxt   = '0;
      end
      else
      begin
        rdy_n_nxt = 1'b1; // RULE6
        gap_nxt   = gap_r + 4'h1;
      end
    end

    // Outgoing bit moves only on a falling SCLK edge inside a read
    dout_nxt = dout_r;
    if (st_r == ASPSR_ST_READ)
    begin
      if (sclk_fall) // RULE8
      begin
        dout_nxt = sh_r[23];
        sh_nxt   = {sh_r[22:0], 1'b0};
      end
    end
    else
      dout_nxt = rdy_n_nxt; // RULE5
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      st_r     <= ASPSR_ST_COMMS;
      cnt_r    <= '0;
      sh_r     <= '0;
      sel_r    <= '0;
      mode_r   <= `ASPSR_MODE_RST;
      cfg_r    <= `ASPSR_CONFIG_RST;
      data_r   <= '0;
      gpocon_r <= `ASPSR_GPOCON_RST;
      full_r   <= 1'b0;
      rdy_n_r  <= 1'b1;
      gap_r    <= '0;
      dout_r   <= 1'b1;
    end
    else
    begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      sh_r     <= sh_nxt;
      sel_r    <= sel_nxt;
      mode_r   <= mode_nxt;
      cfg_r    <= cfg_nxt;
      data_r   <= data_nxt;
      gpocon_r <= gpocon_nxt;
      full_r   <= full_nxt;
      rdy_n_r  <= rdy_n_nxt;
      gap_r    <= gap_nxt;
      dout_r   <= dout_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Pins and core controls
  // ----------------------------------------------------------------------
  logic filt_rst_r, restart_r;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      filt_rst_r <= 1'b1;
      restart_r  <= 1'b0;
    end
    else
    begin
      filt_rst_r <= !sync_s2_r; // RULE1
      restart_r  <= sync_s2_r && !sync_s3_r; // RULE12
    end
  end

  assign filter_reset_out   = filt_rst_r;
  assign filter_restart_out = restart_r;
  assign dout_rdy_out       = dout_r;
  // Pin floats when deselected so several converters can share the line
  assign dout_rdy_oe_n_out  = ser_s2_r.cs_n;
  assign mode_out           = mode_r;
  assign config_out         = cfg_r;
  assign ref2_active_out    = cfg_r[`ASPSR_CFG_REFERENCE_SELECT_BIT]; // RULE10
  assign gpo_out.value      = gpocon_r[3:0]; // RULE11
  assign gpo_out.oe_n       = {2'b00, {2{cfg_r[`ASPSR_CFG_REFERENCE_SELECT_BIT]}}}; // RULE10

endmodule // aspsr_serial_port

`default_nettype wire

// file: aspsr_host_model.sv
/*
  Behavioural host that acts as serial master of the converter port.
  Assumes the bench calls xfer just after a clk_in edge, at 50 ns steps.
*/
`timescale 1ns/10ps
`default_nettype none

module aspsr_host_model
  import aspsr_pkg::*;
(
  output var aspsr_serial_s serial_out,
  input  wire logic         dout_in
);
  initial serial_out = '{cs_n: 1'b1, sclk: 1'b1, din: 1'b0};

  // ----------------------------------------------------------------------
  // One frame: comms byte then nbits of data, MSB first
  // ----------------------------------------------------------------------
  // Clock stands high between frames; din is inverted on release
  task automatic xfer(input logic [7:0] cmd, input int nbits,
                      input logic [23:0] wdata, output logic [23:0] rdata);
    logic [31:0] tx;
    tx = {cmd, wdata << (24 - nbits)};
    rdata = 24'h000000;
    serial_out.cs_n = 1'b0;
    #200;
    for (int i = 0; i < 8 + nbits; i++)
    begin
      serial_out.sclk = 1'b0;
      serial_out.din  = tx[31-i];
      #200;
      if (i >= 8) rdata = {rdata[22:0], dout_in};
      serial_out.sclk = 1'b1;
      #200;
    end
    serial_out.cs_n = 1'b1;
    serial_out.din  = ~serial_out.din;
    #400;
  endtask
endmodule // aspsr_host_model

`default_nettype wire

// file: aspsr_port_checker.sv
/*
  Assertions on the pins of the converter serial port.
  Assumes the bind in the bench and one clk_in domain.
*/
`timescale 1ns/10ps
`default_nettype none

module aspsr_port_checker
  import aspsr_pkg::*;
(
  input wire logic          clk_in,
  input wire logic          reset_in,
  input wire aspsr_serial_s serial_in,
  input wire logic          dout_rdy_out,
  input wire logic          dout_rdy_oe_n_out,
  input wire logic          sync_n_in,
  input wire logic          result_ready_out,
  input wire logic          filter_reset_out,
  input wire logic          filter_restart_out,
  input wire logic [23:0]   mode_out,
  input wire logic [23:0]   config_out,
  input wire logic          ref2_active_out,
  input wire aspsr_gpo_s    gpo_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // ----------------------------------------------------------------------
  // Sync input
  // ----------------------------------------------------------------------
  // Four cycles covers the two synchroniser flops
  sequence s_sync_held;
    (!sync_n_in)[*4];
  endsequence

  property p_sync_filter;
    s_sync_held |-> filter_reset_out;
  endproperty
  a_sync_filter: assert property (p_sync_filter)
    else $error("filter not reset while sync low");

  property p_sync_refuse;
    s_sync_held |-> !result_ready_out;
  endproperty
  a_sync_refuse: assert property (p_sync_refuse)
    else $error("results taken while sync low");

  property p_sync_ready;
    (!sync_n_in && serial_in.cs_n)[*5] |-> dout_rdy_out;
  endproperty
  a_sync_ready: assert property (p_sync_ready)
    else $error("ready pin low while sync low");

  property p_restart;
    $rose(sync_n_in) |-> ##[1:6] filter_restart_out;
  endproperty
  a_restart: assert property (p_restart)
    else $error("no restart after sync release");

  property p_reset_state;
    $fell(reset_in) |-> dout_rdy_out && filter_reset_out && !filter_restart_out;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("wrong state after reset");

  // ----------------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------------
  property p_ref2;
    $changed(config_out[20]) |-> ##[0:2]
      (ref2_active_out == config_out[20] && gpo_out.oe_n[1:0] == {2{config_out[20]}});
  endproperty
  a_ref2: assert property (p_ref2)
    else $error("shared pins do not follow reference select");

  property p_gpo_drive;
    gpo_out.oe_n[3:2] == 2'b00;
  endproperty
  a_gpo_drive: assert property (p_gpo_drive)
    else $error("dedicated outputs not driven");

  property p_oe_on;
    (!serial_in.cs_n)[*4] |-> !dout_rdy_oe_n_out;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("data pin not driven while selected");

  property p_oe_off;
    serial_in.cs_n[*4] |-> dout_rdy_oe_n_out;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("data pin driven while deselected");
endmodule // aspsr_port_checker

`default_nettype wire

// file: tb_top.sv
/*
  Self-checking bench of the converter serial port.
  Assumes the host model and the checker files are compiled first.
*/
`include "aspsr_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module tb_top
  import aspsr_pkg::*;
;
  logic          clk_in = 1'b0;
  logic          reset_in = 1'b1;
  logic          sync_n_in = 1'b1;
  logic          result_valid_in = 1'b0;
  logic [23:0]   result_in = 24'h000000;
  aspsr_serial_s serial_in;
  logic          dout_rdy_out, dout_rdy_oe_n_out, result_ready_out;
  logic          filter_reset_out, filter_restart_out, ref2_active_out;
  logic [23:0]   mode_out, config_out, rd;
  aspsr_gpo_s    gpo_out;
  int            miscompares = 0;
  int            comparisons = 0;

  initial forever #25 clk_in = ~clk_in;

  aspsr_serial_port i_dut (.clk_in, .reset_in, .serial_in, .dout_rdy_out,
    .dout_rdy_oe_n_out, .sync_n_in, .result_in, .result_valid_in,
    .result_ready_out, .filter_reset_out, .filter_restart_out, .mode_out,
    .config_out, .ref2_active_out, .gpo_out);
  aspsr_host_model i_host (.serial_out(serial_in), .dout_in(dout_rdy_out));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask

  // Bounded wait for a level on the ready pin
  task automatic wait_dout(input logic lvl);
    int n;
    n = 0;
    while (dout_rdy_out !== lvl && n < 200)
    begin
      cyc(1);
      n++;
    end
    if (n == 200)
    begin
      check(dout_rdy_out, lvl);
      results();
    end
  endtask

  task automatic reg_io(input logic rd_n, input logic [2:0] sel, input int nbits,
                        input logic [23:0] wd);
    i_host.xfer({1'b0, rd_n, sel, 3'h0}, nbits, wd, rd);
  endtask

  task automatic push(input logic [23:0] v);
    result_in = v;
    result_valid_in = 1'b1;
    cyc(1);
    result_valid_in = 1'b0;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_reset();
    check(dout_rdy_out, 1'b1);
    check(filter_reset_out, 1'b1);
    check(result_ready_out, 1'b1);
    check(mode_out, `ASPSR_MODE_RST);
    check(config_out, `ASPSR_CONFIG_RST);
    $display("test_reset done");
  endtask

  task automatic test_regs();
    reg_io(1'b0, `ASPSR_SEL_MODE, 24, 24'h123456);
    reg_io(1'b0, `ASPSR_SEL_CONFIG, 24, 24'h100abc);
    reg_io(1'b0, `ASPSR_SEL_GPOCON, 8, 24'h00000a);
    check(mode_out, 24'h123456);
    check(ref2_active_out, 1'b1);
    check(gpo_out, {4'ha, 4'b0011});
    reg_io(1'b1, `ASPSR_SEL_MODE, 24, 24'h000000);
    check(rd, 24'h123456);
    reg_io(1'b1, `ASPSR_SEL_ID, 8, 24'h000000);
    check(rd, `ASPSR_ID_VALUE);
    reg_io(1'b1, 3'h6, 8, 24'h000000);
    check(rd, 24'h000000);
    reg_io(1'b0, `ASPSR_SEL_CONFIG, 24, 24'h000abc);
    check(config_out, 24'h000abc);
    check(gpo_out, {4'ha, 4'b0000});
    $display("test_regs done");
  endtask

  task automatic test_ready();
    push(24'habcdef);
    wait_dout(1'b0);
    reg_io(1'b1, `ASPSR_SEL_DATA, 24, 24'h000000);
    check(rd, 24'habcdef);
    check(dout_rdy_out, 1'b1);
    reg_io(1'b1, `ASPSR_SEL_STATUS, 8, 24'h000000);
    check(rd, 24'h000080);
    push(24'h111111);
    wait_dout(1'b0);
    push(24'h222222);
    wait_dout(1'b1);
    wait_dout(1'b0);
    reg_io(1'b1, `ASPSR_SEL_DATA, 24, 24'h000000);
    check(rd, 24'h222222);
    $display("test_ready done");
  endtask

  task automatic test_sync();
    push(24'h333333);
    wait_dout(1'b0);
    sync_n_in = 1'b0;
    cyc(5);
    check(dout_rdy_out, 1'b1);
    check(filter_reset_out, 1'b1);
    check(result_ready_out, 1'b0);
    reg_io(1'b0, `ASPSR_SEL_MODE, 24, 24'h0a0b0c);
    reg_io(1'b1, `ASPSR_SEL_MODE, 24, 24'h000000);
    check(rd, 24'h0a0b0c);
    sync_n_in = 1'b1;
    wait_dout(1'b1);
    cyc(6);
    check(filter_reset_out, 1'b0);
    reg_io(1'b1, `ASPSR_SEL_DATA, 24, 24'h000000);
    $display("test_sync done");
  endtask

  task automatic test_fill();
    int   acc;
    int   refused;
    logic ok;
    acc = 0;
    refused = 0;
    result_valid_in = 1'b1;
    for (int i = 0; i < 60; i++)
    begin
      result_in = 24'h000100 + 24'(acc);
      ok = result_ready_out;
      cyc(1);
      if (ok === 1'b1) acc++;
      else refused++;
    end
    result_valid_in = 1'b0;
    check(24'(refused > 0), 24'h000001);
    check(24'(acc >= `ASPSR_FIFO_DEPTH), 24'h000001);
    // Unread words keep replacing each other until the FIFO runs dry
    cyc(150);
    reg_io(1'b1, `ASPSR_SEL_DATA, 24, 24'h000000);
    check(rd, 24'h000100 + 24'(acc - 1));
    sync_n_in = 1'b0;
    cyc(5);
    sync_n_in = 1'b1;
    cyc(5);
    check(result_ready_out, 1'b1);
    $display("test_fill done");
  endtask

  initial
  begin
    cyc(10);
    test_reset();
    cyc(2);
    reset_in = 1'b0;
    cyc(4);
    test_regs();
    test_ready();
    test_sync();
    test_fill();
    results();
  end
endmodule // tb_top

bind aspsr_serial_port aspsr_port_checker i_chk (.clk_in, .reset_in, .serial_in,
  .dout_rdy_out, .dout_rdy_oe_n_out, .sync_n_in, .result_ready_out,
  .filter_reset_out, .filter_restart_out, .mode_out, .config_out,
  .ref2_active_out, .gpo_out);

`default_nettype wire
